// *** msc_pkg.sv ***
// Constants, field layouts and types for the mode setting configuration bank
// What this block does
// - System buck mode 2: 1.5 V+25 mV/step, clamp 2.1 V
// - Always-on level nibble upper, resets to 0100
// - Always-on level: 1.7 V+25 mV, clamp 1.9 V
// - Bits 3,2 enable core/system buck, reset 1
// - Bits 1,0 enable always-on/system regulator, reset 1
// - Watchdog code: off, 16 s, 32 s, 64 s
// - System regulator offset bit adds 1.2 V
// - System regulator level resets 01100, clamp 2.1 V
// - Mode 3 bit 7 enters ship mode
// - Mode 3 bit 6 picks pins or register bits
// - Core buck level bits 5:0, reset 011100
// - Core buck: 0.5 V+25 mV, clamp 1.5, 111111=1.8
// - All registers read back last written value
// - System buck adds 1.2 V when offset set
`default_nettype none

package msc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] MSC_ADDR_M2_RAIL = 8'h2c; // Rail enables, aon level
  localparam logic [7:0] MSC_ADDR_M2_WD   = 8'h2d; // Watchdog, sysreg level
  localparam logic [7:0] MSC_ADDR_M3_CORE = 8'h2e; // Ship, source, core

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  typedef struct packed {
    logic [3:0] aon_reg_level_m2;     // Always-on regulator level code
    logic       core_buck_enable_m2;  // Bit 3
    logic       system_buck_enable_m2;// Bit 2
    logic       aon_reg_enable_m2;    // Bit 1
    logic       system_reg_enable_m2; // Bit 0
  } msc_m2_rail_type;

  typedef struct packed {
    logic [1:0] watchdog_period_m2;   // Watchdog period code
    logic       system_reg_offset_m2; // Adds the high range offset
    logic [4:0] system_reg_level_m2;  // System regulator level code
  } msc_m2_wd_type;

  typedef struct packed {
    logic       ship_en_m3;           // Ship mode request
    logic       mode_source_pins_m3;  // 1: pins choose the mode
    logic [5:0] core_buck_level_m3;   // Core buck level code
  } msc_m3_core_type;

  // Rail enables presented to the analog side
  typedef struct packed {
    logic core_buck;
    logic system_buck;
    logic aon_regulator;
    logic system_regulator;
  } msc_rails_type;

  // Mode settings as seen by the mode-switch logic
  typedef enum logic [1:0] {
    MSC_MODE0 = 2'b00,
    MSC_MODE1 = 2'b01,
    MSC_MODE2 = 2'b10,
    MSC_MODE3 = 2'b11
  } msc_mode_type;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam msc_m2_rail_type MSC_RST_M2_RAIL = 8'h4f; // 0100_1111
  localparam msc_m2_wd_type   MSC_RST_M2_WD   = 8'h0c; // 00_0_01100
  localparam msc_m3_core_type MSC_RST_M3_CORE = 8'h1c; // 0_0_011100

  // ****************************************************************
  // Level coding; levels in millivolts, tops and special codes as level codes
  // ****************************************************************
  localparam int          MSC_MV_W       = 12;
  localparam logic [11:0] MSC_STEP_MV    = 12'h019; // 25 mV
  localparam logic [11:0] MSC_OFFSET_MV  = 12'h4b0; // 1200 mV
  localparam logic [11:0] MSC_OFF_MV     = 12'h000; // Shown when inactive
  localparam logic [11:0] MSC_SYS_BASE   = 12'h5dc; // 1500 mV
  localparam logic [11:0] MSC_SYS_CLAMP  = 12'h834; // 2100 mV
  localparam logic [11:0] MSC_SYS_TOP    = 12'h018; // Code 11000
  localparam logic [11:0] MSC_AON_BASE   = 12'h6a4; // 1700 mV
  localparam logic [11:0] MSC_AON_CLAMP  = 12'h76c; // 1900 mV
  localparam logic [11:0] MSC_AON_TOP    = 12'h008; // Code 1000
  localparam logic [11:0] MSC_CORE_BASE  = 12'h1f4; // 500 mV
  localparam logic [11:0] MSC_CORE_CLAMP = 12'h5dc; // 1500 mV
  localparam logic [11:0] MSC_CORE_TOP   = 12'h028; // Code 101000
  localparam logic [11:0] MSC_CORE_SPEC  = 12'h03f; // Code 111111
  localparam logic [11:0] MSC_CORE_SPMV  = 12'h708; // 1800 mV
  localparam logic [11:0] MSC_NO_SPEC    = 12'hfff; // Above any code

  // ****************************************************************
  // Watchdog periods in seconds
  // ****************************************************************
  localparam logic [1:0] MSC_WD_OFF   = 2'h0;
  localparam logic [6:0] MSC_WD_P1_S  = 7'h10; // 16 s
  localparam logic [6:0] MSC_WD_P2_S  = 7'h20; // 32 s
  localparam logic [6:0] MSC_WD_P3_S  = 7'h40; // 64 s
  localparam logic [6:0] MSC_WD_NONE  = 7'h00;

endpackage : msc_pkg

`default_nettype wire

// *** msc_level_decode.sv ***
// Code to millivolt decoder with linear range, clamp and one special code
`default_nettype none

module msc_level_decode
  import msc_pkg::*;
#(
  parameter int          CODE_W  = 5,            // Width of the level code
  parameter logic [11:0] BASE_MV = MSC_SYS_BASE, // Level at code zero
  parameter logic [11:0] TOP     = MSC_SYS_TOP,  // Last linear code
  parameter logic [11:0] CLAMP   = MSC_SYS_CLAMP,// Level above the top
  parameter logic [11:0] SPEC    = MSC_NO_SPEC,  // Code with its own level
  parameter logic [11:0] SPEC_MV = MSC_OFF_MV    // Level of that code
) (
  input  wire logic [CODE_W-1:0]   i_code,  // Level code
  output logic      [MSC_MV_W-1:0] o_mv     // Decoded level
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Widened code so the compare and product stay at level width
  wire logic [11:0] code_w;
  wire logic [11:0] linear_mv;
  wire logic        in_range;
  wire logic        is_spec;

  assign code_w    = 12'(i_code);
  assign linear_mv = BASE_MV + code_w * MSC_STEP_MV;
  assign in_range  = (code_w <= TOP);
  assign is_spec   = (code_w == SPEC);

  // Special code is checked first; the clamp covers the rest
  assign o_mv = is_spec  ? SPEC_MV   :
                in_range ? linear_mv : CLAMP;

endmodule : msc_level_decode

`default_nettype wire

// *** msc_bank.sv ***
// Mode setting 2 and 3 configuration registers with decoded outputs
`default_nettype none

module msc_bank
  import msc_pkg::*;
(
  input  wire logic                  i_clk,          // 100 MHz
  input  wire logic                  i_rstn,         // Async, active low
  input  wire logic                  i_wr_en,        // Register write
  input  wire logic                  i_rd_en,        // Register read
  input  wire logic [7:0]            i_addr,         // Register address
  input  wire logic [7:0]            i_wdata,        // Write data
  input  wire msc_pkg::msc_mode_type i_active_mode,  // Mode now in force
  input  wire logic [4:0]            i_system_buck_level_m2, // From 2Bh
  input  wire logic                  i_system_buck_offset_m2,// From 2Bh
  input  wire logic                  i_mode_select_bit_a,    // Register
  input  wire logic                  i_mode_select_bit_b,    // Register
  input  wire logic                  i_mode_select_pin_a,    // Pin
  input  wire logic                  i_mode_select_pin_b,    // Pin
  output logic [7:0]                 o_rdata,        // Read data
  output logic                       o_rd_valid,     // Read data valid
  output msc_pkg::msc_rails_type     o_rails,        // Rail enables
  output logic [11:0]                o_aon_mv,       // Always-on level
  output logic [11:0]                o_sysreg_mv,    // System regulator
  output logic [11:0]                o_sysbuck_mv,   // System buck
  output logic [11:0]                o_core_mv,      // Core buck level
  output logic                       o_wd_en,        // Watchdog running
  output logic [6:0]                 o_wd_period_s,  // Watchdog period
  output logic                       o_ship_mode,    // Enter ship mode
  output logic [1:0]                 o_mode_request  // Requested mode
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  msc_m2_rail_type rail_r;   // Rail enables and always-on level
  msc_m2_wd_type   wd_r;     // Watchdog and system regulator level
  msc_m3_core_type core_r;   // Ship, mode source and core level

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic hit_rail;
  wire logic hit_wd;
  wire logic hit_core;
  wire logic [7:0] rd_mux;   // Unmapped addresses read as zero

  assign hit_rail = (i_addr == MSC_ADDR_M2_RAIL);
  assign hit_wd   = (i_addr == MSC_ADDR_M2_WD);
  assign hit_core = (i_addr == MSC_ADDR_M3_CORE);
  assign rd_mux   = hit_rail ? rail_r :
                    hit_wd   ? wd_r   :
                    hit_core ? core_r : 8'h00;

  // Register writes; every field is plain read/write
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rail_r <= MSC_RST_M2_RAIL;
      wd_r   <= MSC_RST_M2_WD;
      core_r <= MSC_RST_M3_CORE;
    end else if (i_wr_en) begin
      if (hit_rail) rail_r <= i_wdata;
      if (hit_wd)   wd_r   <= i_wdata;
      if (hit_core) core_r <= i_wdata;
    end
  end

  // Read data is registered so it comes straight from a flip-flop
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata    <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) o_rdata <= rd_mux;
    end
  end

  // ****************************************************************
  // Mode select pins
  // ****************************************************************
  // Two stages; only the second one is read by logic
  logic [1:0] pin_meta_r;
  logic [1:0] pin_sync_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta_r <= 2'b00;
      pin_sync_r <= 2'b00;
    end else begin
      pin_meta_r <= {i_mode_select_pin_b, i_mode_select_pin_a};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ****************************************************************
  // Level decoders
  // ****************************************************************
  wire logic [11:0] aon_dec;
  wire logic [11:0] sysreg_dec;
  wire logic [11:0] sysbuck_dec;
  wire logic [11:0] core_dec;

  // Always-on regulator, clamps at 1.9 V
  msc_level_decode #(
    .CODE_W (4),
    .BASE_MV(MSC_AON_BASE),
    .TOP    (MSC_AON_TOP),
    .CLAMP  (MSC_AON_CLAMP)
  ) u_aon_dec (
    .i_code(rail_r.aon_reg_level_m2),
    .o_mv  (aon_dec)
  );

  // System regulator, base range before the offset
  msc_level_decode #(
    .CODE_W (5),
    .BASE_MV(MSC_SYS_BASE),
    .TOP    (MSC_SYS_TOP),
    .CLAMP  (MSC_SYS_CLAMP)
  ) u_sysreg_dec (
    .i_code(wd_r.system_reg_level_m2),
    .o_mv  (sysreg_dec)
  );

  // System buck, same coding as the system regulator
  msc_level_decode #(
    .CODE_W (5),
    .BASE_MV(MSC_SYS_BASE),
    .TOP    (MSC_SYS_TOP),
    .CLAMP  (MSC_SYS_CLAMP)
  ) u_sysbuck_dec (
    .i_code(i_system_buck_level_m2),
    .o_mv  (sysbuck_dec)
  );

  // Core buck, with one code reserved for the fixed 1.8 V
  msc_level_decode #(
    .CODE_W (6),
    .BASE_MV(MSC_CORE_BASE),
    .TOP    (MSC_CORE_TOP),
    .CLAMP  (MSC_CORE_CLAMP),
    .SPEC   (MSC_CORE_SPEC),
    .SPEC_MV(MSC_CORE_SPMV)
  ) u_core_dec (
    .i_code(core_r.core_buck_level_m3),
    .o_mv  (core_dec)
  );

  // ****************************************************************
  // Output selection
  // ****************************************************************
  wire logic          m2_act;
  wire logic          m3_act;
  wire logic [11:0]   sysreg_mv;
  wire logic [11:0]   sysbuck_mv;
  wire logic [6:0]    wd_period;
  wire logic [1:0]    mode_req;
  wire msc_rails_type rails;

  assign m2_act = (i_active_mode == MSC_MODE2);
  assign m3_act = (i_active_mode == MSC_MODE3);

  // Offset lifts the range to 2.7 V .. 3.3 V
  assign sysreg_mv  = wd_r.system_reg_offset_m2 ?
                      sysreg_dec + MSC_OFFSET_MV : sysreg_dec;
  assign sysbuck_mv = i_system_buck_offset_m2 ?
                      sysbuck_dec + MSC_OFFSET_MV : sysbuck_dec;

  assign wd_period = (wd_r.watchdog_period_m2 == 2'h1) ? MSC_WD_P1_S :
                     (wd_r.watchdog_period_m2 == 2'h2) ? MSC_WD_P2_S :
                     (wd_r.watchdog_period_m2 == 2'h3) ? MSC_WD_P3_S :
                     MSC_WD_NONE;

  // Pins are ignored unless mode 3 hands control to them
  assign mode_req = (m3_act && core_r.mode_source_pins_m3) ?
                    pin_sync_r :
                    {i_mode_select_bit_b, i_mode_select_bit_a};

  assign rails.core_buck        = m2_act & rail_r.core_buck_enable_m2;
  assign rails.system_buck      = m2_act & rail_r.system_buck_enable_m2;
  assign rails.aon_regulator    = m2_act & rail_r.aon_reg_enable_m2;
  assign rails.system_regulator = m2_act & rail_r.system_reg_enable_m2;

  // Outputs are registered; values from other modes are left to the
  // logic that owns them, so here an inactive field reads as off
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rails        <= '0;
      o_aon_mv       <= MSC_OFF_MV;
      o_sysreg_mv    <= MSC_OFF_MV;
      o_sysbuck_mv   <= MSC_OFF_MV;
      o_core_mv      <= MSC_OFF_MV;
      o_wd_en        <= 1'b0;
      o_wd_period_s  <= MSC_WD_NONE;
      o_ship_mode    <= 1'b0;
      o_mode_request <= 2'b00;
    end else begin
      o_rails        <= rails;
      o_aon_mv       <= m2_act ? aon_dec    : MSC_OFF_MV;
      o_sysreg_mv    <= m2_act ? sysreg_mv  : MSC_OFF_MV;
      o_sysbuck_mv   <= m2_act ? sysbuck_mv : MSC_OFF_MV;
      o_core_mv      <= m3_act ? core_dec   : MSC_OFF_MV;
      o_wd_en        <= m2_act &&
                        (wd_r.watchdog_period_m2 != MSC_WD_OFF);
      o_wd_period_s  <= m2_act ? wd_period  : MSC_WD_NONE;
      o_ship_mode    <= m3_act & core_r.ship_en_m3;
      o_mode_request <= mode_req;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // The host leaves one idle cycle between accesses, so the read of the
  // same register comes two edges after the write
  a_write_read_back: assert property (
    (i_wr_en && i_addr == MSC_ADDR_M2_WD) ##1
    !(i_wr_en && i_addr == MSC_ADDR_M2_WD) ##1
    (i_rd_en && !i_wr_en && i_addr == MSC_ADDR_M2_WD)
    |=> o_rd_valid && o_rdata == $past(i_wdata, 3))
    else $error("read back differs from written value");

  a_unmapped_zero: assert property (
    (i_rd_en && !hit_rail && !hit_wd && !hit_core)
    |=> o_rd_valid && o_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_aon_clamp: assert property (
    (m2_act && rail_r.aon_reg_level_m2 > 4'h8)
    |=> o_aon_mv == MSC_AON_CLAMP)
    else $error("always-on level not clamped");

  a_aon_default: assert property (
    (m2_act && rail_r.aon_reg_level_m2 == 4'h4)
    |=> o_aon_mv == 12'h708)
    else $error("always-on default level wrong");

  a_core_special: assert property (
    (m3_act && core_r.core_buck_level_m3 == 6'h3f)
    |=> o_core_mv == MSC_CORE_SPMV)
    else $error("core special code wrong");

  a_core_clamp: assert property (
    (m3_act && core_r.core_buck_level_m3 > 6'h28 &&
     core_r.core_buck_level_m3 < 6'h3f)
    |=> o_core_mv == MSC_CORE_CLAMP)
    else $error("core level not clamped");

  a_sysreg_offset: assert property (
    (m2_act && wd_r.system_reg_offset_m2 &&
     wd_r.system_reg_level_m2 == 5'h00)
    |=> o_sysreg_mv == 12'ha8c)
    else $error("system regulator offset wrong");

  a_sysbuck_level: assert property (
    (m2_act && !i_system_buck_offset_m2 &&
     i_system_buck_level_m2 == 5'h1f)
    |=> o_sysbuck_mv == MSC_SYS_CLAMP)
    else $error("system buck clamp wrong");

  a_inactive_off: assert property (
    (!m2_act) |=> (o_rails == '0 && !o_wd_en && o_aon_mv == MSC_OFF_MV))
    else $error("mode 2 field shown while inactive");

  a_ship_mode: assert property (
    (m3_act && core_r.ship_en_m3) |=> o_ship_mode)
    else $error("ship mode not entered");

  a_watchdog_16s: assert property (
    (m2_act && wd_r.watchdog_period_m2 == 2'h1)
    |=> o_wd_en && o_wd_period_s == MSC_WD_P1_S)
    else $error("watchdog period wrong");

  a_pins_ignored: assert property (
    (!core_r.mode_source_pins_m3)
    |=> o_mode_request[1] == $past(i_mode_select_bit_b) &&
        o_mode_request[0] == $past(i_mode_select_bit_a))
    else $error("pins used while register bits own the mode");

  a_pins_used: assert property (
    (m3_act && core_r.mode_source_pins_m3)
    |=> o_mode_request == $past(pin_sync_r))
    else $error("pins not used while they own the mode");

  a_core_inactive: assert property (
    (!m3_act) |=> (o_core_mv == MSC_OFF_MV && !o_ship_mode))
    else $error("mode 3 field shown while inactive");

  a_sysreg_clamp: assert property (
    (m2_act && !wd_r.system_reg_offset_m2 &&
     wd_r.system_reg_level_m2 > 5'h18)
    |=> o_sysreg_mv == MSC_SYS_CLAMP)
    else $error("system regulator level not clamped");

endmodule : msc_bank

`default_nettype wire

// *** msc_host_model.sv ***
// Host side bus model that issues register writes and reads to the bank
`default_nettype none

module msc_host_model (
  input  wire logic       i_clk,   // Bus clock, 100 MHz
  output logic            o_wr_en, // Write strobe
  output logic            o_rd_en, // Read strobe
  output logic [7:0]      o_addr,  // Register address
  output logic [7:0]      o_wdata  // Write data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Idle bus
  // ****************************************************************
  // Strobes low from time zero so nothing is taken during reset
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // ****************************************************************
  // One access
  // ****************************************************************
  // Entered just after a rising edge; held through the taking edge.
  // Released address and data are inverted so a stale value can never pass for
  // a good one, and one idle cycle keeps each strobe a clean pulse.
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
    o_wr_en = wr;
    o_rd_en = ~wr;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
    @(posedge i_clk);
    #1;
  endtask
endmodule // msc_host_model

`default_nettype wire

// *** msc_bank_test.sv ***
// Self-checking testbench for the mode setting configuration bank
`default_nettype none

module msc_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import msc_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic          i_clk;          // 100 MHz clock
  logic          i_rstn;         // Active low reset
  logic          wr_en, rd_en;   // Strobes from the host model
  logic [7:0]    addr, wdata;    // Address and data from the host model
  msc_mode_type  mode;           // Mode in force
  logic [4:0]    buck_lvl;       // System buck level code
  logic          buck_off;       // System buck offset bit
  logic          bit_a, bit_b;   // Register mode bits
  logic          pin_a, pin_b;   // External mode pins
  logic [7:0]    o_rdata;        // Read data
  logic          o_rd_valid;     // Read data valid
  msc_rails_type o_rails;        // Rail enables
  logic [11:0]   o_aon_mv, o_sysreg_mv, o_sysbuck_mv, o_core_mv;
  logic          o_wd_en, o_ship_mode;
  logic [6:0]    o_wd_period_s;  // Watchdog period
  logic [1:0]    o_mode_request; // Requested mode
  logic [7:0]    mdl [3];        // Expected register contents
  logic [7:0]    exp_q [$];      // Expected read data, oldest first
  logic [31:0]   r;              // Random draw
  int            err_count, total_checks, cycle_count;

  msc_host_model i_msc_host_model (.i_clk(i_clk), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

  msc_bank i_msc_bank (.i_clk(i_clk), .i_rstn(i_rstn), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .i_active_mode(mode), .i_system_buck_level_m2(buck_lvl),
    .i_system_buck_offset_m2(buck_off), .i_mode_select_bit_a(bit_a),
    .i_mode_select_bit_b(bit_b), .i_mode_select_pin_a(pin_a),
    .i_mode_select_pin_b(pin_b), .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid), .o_rails(o_rails), .o_aon_mv(o_aon_mv),
    .o_sysreg_mv(o_sysreg_mv), .o_sysbuck_mv(o_sysbuck_mv),
    .o_core_mv(o_core_mv), .o_wd_en(o_wd_en),
    .o_wd_period_s(o_wd_period_s), .o_ship_mode(o_ship_mode),
    .o_mode_request(o_mode_request));

  // ****************************************************************
  // Compare tasks and expected levels
  // ****************************************************************
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] exp_aon(input logic [3:0] c);
    return (c > 4'h8) ? MSC_AON_CLAMP : MSC_AON_BASE + MSC_STEP_MV * c;
  endfunction

  // Offset is added after the clamp, so clamped codes reach 3.3 V too
  function automatic logic [11:0] exp_sys(input logic [4:0] c,
                                          input logic off);
    return ((c > 5'h18) ? MSC_SYS_CLAMP : MSC_SYS_BASE + MSC_STEP_MV * c)
           + (off ? MSC_OFFSET_MV : 12'h000);
  endfunction

  function automatic logic [11:0] exp_core(input logic [5:0] c);
    if (c == 6'h3f) return MSC_CORE_SPMV;
    return (c > 6'h28) ? MSC_CORE_CLAMP : MSC_CORE_BASE + MSC_STEP_MV * c;
  endfunction

  // All decoded outputs against the register copy and the inputs
  task automatic check_outs();
    logic m2, m3;
    logic [1:0] wd;
    logic [11:0] sr, sb, wp, mr;
    m2 = (mode == MSC_MODE2);
    m3 = (mode == MSC_MODE3);
    wd = mdl[1][7:6];
    sr = m2 ? exp_sys(mdl[1][4:0], mdl[1][5]) : 12'h000;
    sb = m2 ? exp_sys(buck_lvl, buck_off) : 12'h000;
    wp = 12'h000;
    if (m2 && wd == 2'h1) wp = 12'(MSC_WD_P1_S);
    if (m2 && wd == 2'h2) wp = 12'(MSC_WD_P2_S);
    if (m2 && wd == 2'h3) wp = 12'(MSC_WD_P3_S);
    mr = {10'h000, bit_b, bit_a};
    if (m3 & mdl[2][6]) mr = {10'h000, pin_b, pin_a};
    chk_val(12'(o_rails), m2 ? 12'(mdl[0][3:0]) : 12'h000);
    chk_val(o_aon_mv, m2 ? exp_aon(mdl[0][7:4]) : 12'h000);
    chk_val(o_sysreg_mv, sr);
    chk_val(o_sysbuck_mv, sb);
    chk_val(o_core_mv, m3 ? exp_core(mdl[2][5:0]) : 12'h000);
    chk_val(12'(o_wd_en), 12'(m2 && wd != 2'h0));
    chk_val(12'(o_wd_period_s), wp);
    chk_val(12'(o_ship_mode), 12'(m3 & mdl[2][7]));
    chk_val(12'(o_mode_request), mr);
  endtask

  // ****************************************************************
  // Bus helpers
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_msc_host_model.access(1'b1, a, d);
    if (a >= 8'h2c && a <= 8'h2e) mdl[a - 8'h2c] = d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_msc_host_model.access(1'b0, a, 8'h00);
  endtask

  // Unmapped 0x2f must read as zero
  task automatic readall();
    rd(8'h2c, mdl[0]);
    rd(8'h2d, mdl[1]);
    rd(8'h2e, mdl[2]);
    rd(8'h2f, 8'h00);
  endtask

  // ****************************************************************
  // Read monitor: oldest note is taken whenever read data appears
  // ****************************************************************
  always begin
    @(posedge i_clk);
    #2;
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk_rd(o_rdata, exp_q.pop_front());
      end else begin
        err_count++;
        $display("mismatch at %0t: got %h expected none", $time, o_rdata);
      end
    end
  end

  // ****************************************************************
  // Clock, timeout and closing report
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Loop needs about 2200 cycles; the ceiling leaves ample margin
  always @(posedge i_clk) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i_rstn = 1'b0;
    mode = MSC_MODE2;
    {buck_off, buck_lvl, bit_b, bit_a, pin_b, pin_a} = 10'h000;
    mdl = '{8'h4f, 8'h0c, 8'h1c};
    void'($urandom(44671));
    repeat (4) @(posedge i_clk);
    #1;
    chk_val(12'(o_rails), 12'h000);
    chk_val(o_aon_mv, 12'h000);
    i_rstn = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    check_outs();
    readall();
    // Every always-on, system regulator and core level code, each seen in all four modes
    for (int i = 0; i < 64; i++) begin
      r = $urandom;
      wr(8'h2c, {i[3:0], r[3:0]});
      wr(8'h2d, {r[5:4], i[5:0]});
      rd(8'h2d, mdl[1]);
      wr(8'h2e, {r[7:6], i[5:0]});
      wr(8'h2b, r[15:8]);
      readall();
      for (int m = 0; m < 4; m++) begin
        r = $urandom;
        mode = msc_mode_type'(m[1:0]);
        {buck_off, buck_lvl, bit_b, bit_a, pin_b, pin_a} = r[9:0];
        repeat (4) @(posedge i_clk);
        #1;
        check_outs();
      end
    end
    // Second reset in mid run, in mode 3 with fields set
    i_rstn = 1'b0;
    @(posedge i_clk);
    #1;
    chk_val(o_core_mv, 12'h000);
    chk_val(12'(o_ship_mode), 12'h000);
    i_rstn = 1'b1;
    mdl = '{8'h4f, 8'h0c, 8'h1c};
    repeat (2) @(posedge i_clk);
    #1;
    check_outs();
    readall();
    mode = MSC_MODE2;
    // Top system buck code without offset must sit on the clamp
    {buck_off, buck_lvl} = 6'h1f;
    repeat (4) @(posedge i_clk);
    #1;
    check_outs();
    // Every read issued must have been answered by now
    chk_val(12'(exp_q.size()), 12'h000);
    wrap_up();
  end
endmodule // msc_bank_test

`default_nettype wire
